// ==== cache_pkg.sv ====
// shared geometry, policy codes and cache identifiers for the core cache block
package cache_pkg;

   // ==========================================================
   // geometry
   localparam int ADDR_W     = 32;
   localparam int WORD_W     = 32;
   localparam int LINE_BYTES = 32;
   localparam int LINE_WORDS = 8;
   localparam int LINE_W     = 256;
   localparam int SETS       = 32;
   localparam int WAYS       = 32;
   localparam int MINI_WAYS  = 2;
   localparam int WAY_SPAN   = 1024;
   localparam int OFF_W      = 5;
   localparam int SET_W      = 5;
   localparam int TAG_W      = 22;
   localparam int TAG_LSB    = 10;
   localparam int WSEL_LSB   = 2;

   // ==========================================================
   // region attribute codes {x, c, b}
   localparam logic [2:0] ATTR_NC      = 3'h0;
   localparam logic [2:0] ATTR_NC_COAL = 3'h1;
   localparam logic [2:0] ATTR_WT_RA   = 3'h2;
   localparam logic [2:0] ATTR_WB_RA   = 3'h3;
   localparam logic [2:0] ATTR_WB_RWA  = 3'h7;

   // ==========================================================
   // cache identifiers
   localparam int          NCACHE = 3;
   localparam logic [1:0]  CID_I  = 2'h0;
   localparam logic [1:0]  CID_D  = 2'h1;
   localparam logic [1:0]  CID_M  = 2'h2;

endpackage

// ==== core_cache.sv ====
// instruction, data and mini-data cache controller with policies, locking and retry
`timescale 1ns/100ps
`default_nettype none
module core_cache #(
   parameter int WAYS      = cache_pkg::WAYS,
   parameter int MINI_WAYS = cache_pkg::MINI_WAYS,
   parameter int SETS      = cache_pkg::SETS
) (
   // clock and reset
   input  wire logic                          clock,
   input  wire logic                          rst,
   // core request
   input  wire logic                          req_valid,
   input  wire logic                          req_fetch,
   input  wire logic                          req_write,
   input  wire logic                          req_mini,
   input  wire logic                          req_lock,
   input  wire logic                          req_slow,
   input  wire logic [2:0]                    req_attr,
   input  wire logic [cache_pkg::ADDR_W-1:0]  req_addr,
   input  wire logic [cache_pkg::WORD_W-1:0]  req_wdata,
   // core answer
   output logic                               resp_valid_q,
   output logic                               resp_retry_q,
   output logic                               resp_hit_q,
   output logic      [cache_pkg::WORD_W-1:0]  resp_rdata_q,
   // control
   input  wire logic                          icache_en,
   input  wire logic                          unlock_all,
   // memory side
   output logic                               mem_req_q,
   output logic                               mem_write_q,
   output logic      [cache_pkg::ADDR_W-1:0]  mem_addr_q,
   output logic      [cache_pkg::LINE_W-1:0]  mem_wline_q,
   output logic      [cache_pkg::LINE_WORDS-1:0] mem_wmask_q,
   input  wire logic                          mem_ack,
   input  wire logic [cache_pkg::LINE_W-1:0]  mem_rline
);
   localparam int W    = $clog2(WAYS);
   localparam int AW   = cache_pkg::ADDR_W;
   localparam int LW   = cache_pkg::LINE_W;
   localparam int NW   = cache_pkg::LINE_WORDS;
   localparam int NC   = cache_pkg::NCACHE;
   localparam int TW   = cache_pkg::TAG_W;
   localparam int SW   = cache_pkg::SET_W;
   localparam int LADR = AW - cache_pkg::OFF_W;

   typedef enum logic [2:0] {st_idle, st_flush, st_evict, st_fill, st_bus} state_e;

   // ==========================================================
   // helpers
   function automatic logic [31:0] word_of(input logic [LW-1:0] l, input logic [2:0] i);
      return l[{i, 5'h0} +: 32];
   endfunction

   function automatic logic [LW-1:0] put_word(input logic [LW-1:0] l, input logic [2:0] i,
                                               input logic [31:0] w);
      logic [LW-1:0] r;
      r = l;
      r[{i, 5'h0} +: 32] = w;
      return r;
   endfunction

   // ==========================================================
   // storage; tag and data need no reset, valid/dirty/lock/pointer do
   logic [TW-1:0]   tag_q   [NC][SETS][WAYS];
   logic [LW-1:0]   data_q  [NC][SETS][WAYS];
   logic [WAYS-1:0] val_q   [NC][SETS];
   logic [WAYS-1:0] dirty_q [NC][SETS];
   logic [WAYS-1:0] lock_q  [NC][SETS];
   logic [W-1:0]    ptr_q   [NC][SETS];

   // ==========================================================
   // control state
   state_e         state_q, state_d;
   logic [1:0]     op_cid_q, op_cid_d;
   logic [W-1:0]   op_way_q, op_way_d;
   logic [AW-1:0]  op_addr_q, op_addr_d;
   logic [31:0]    op_wdata_q, op_wdata_d;
   logic           op_write_q, op_write_d;
   logic           op_lock_q, op_lock_d;
   logic           op_slow_q, op_slow_d;
   logic           cb_valid_q, cb_valid_d;
   logic [LADR-1:0] cb_line_q, cb_line_d;
   logic [LW-1:0]  cb_data_q, cb_data_d;
   logic [NW-1:0]  cb_mask_q, cb_mask_d;
   logic           resp_valid_d, resp_retry_d, resp_hit_d;
   logic [31:0]    resp_rdata_d;
   logic           mem_req_d, mem_write_d;
   logic [AW-1:0]  mem_addr_d;
   logic [LW-1:0]  mem_wline_d;
   logic [NW-1:0]  mem_wmask_d;

   // array write port
   logic           a_we, a_dirty, a_lock, a_lock_only, a_alloc;
   logic [1:0]     a_cid;
   logic [SW-1:0]  a_set;
   logic [W-1:0]   a_way, a_ptr;
   logic [TW-1:0]  a_tag;
   logic [LW-1:0]  a_line;

   // ==========================================================
   // lookup of the presented request
   logic            wr, cacheable, is_wb, is_rwa, hit, none, alloc_req;
   logic            to_cache_only, bus_write, coal, same_line;
   logic [1:0]      cid;
   logic [SW-1:0]   set;
   logic [TW-1:0]   tag;
   logic [2:0]      widx;
   logic [W-1:0]    hway, victim, last_way;
   logic [WAYS-1:0] wmask;
   logic [LW-1:0]   hline;

   assign wr   = req_write & ~req_fetch;
   assign cid  = req_fetch ? cache_pkg::CID_I : (req_mini ? cache_pkg::CID_M : cache_pkg::CID_D);
   assign set  = req_addr[cache_pkg::OFF_W +: SW];
   assign tag  = req_addr[AW-1:cache_pkg::TAG_LSB];
   assign widx = req_addr[cache_pkg::WSEL_LSB +: 3];
   assign wmask = (cid == cache_pkg::CID_M) ? WAYS'((1 << MINI_WAYS) - 1) : '1;
   assign last_way = (cid == cache_pkg::CID_M) ? W'(MINI_WAYS - 1) : W'(WAYS - 1);

   // policy is read from each access, so a change applies from the next one on
   always_comb begin
      is_wb  = (req_attr == cache_pkg::ATTR_WB_RA) || (req_attr == cache_pkg::ATTR_WB_RWA);
      is_rwa = (req_attr == cache_pkg::ATTR_WB_RWA);
      if (req_slow) begin
         cacheable = 1'b0;
      end else if (req_fetch) begin
         cacheable = icache_en;
      end else begin
         cacheable = is_wb || (req_attr == cache_pkg::ATTR_WT_RA);
      end
   end

   always_comb begin
      hit  = 1'b0;
      hway = '0;
      for (int w = 0; w < WAYS; w++) begin
         if (wmask[w] && val_q[cid][set][w] && tag_q[cid][set][w] == tag) begin
            hit  = 1'b1;
            hway = W'(w);
         end
      end
   end

   rr_victim #(
      .WAYS (WAYS)
   ) u_victim (
      .ptr    (ptr_q[cid][set]),
      .avail  (wmask & ~lock_q[cid][set]),
      .victim (victim),
      .none   (none)
   );

   assign hline         = data_q[cid][set][hway];
   assign alloc_req     = cacheable & ~hit & (~wr | is_rwa) & ~none;
   assign to_cache_only = cacheable & wr & hit & is_wb;
   assign bus_write     = wr & ~to_cache_only & ~alloc_req;
   assign coal          = bus_write & ~req_slow & (req_attr != cache_pkg::ATTR_NC);
   assign same_line     = cb_line_q == req_addr[AW-1:cache_pkg::OFF_W];

   // ==========================================================
   // next-state logic
   always_comb begin
      state_d      = state_q;
      op_cid_d     = op_cid_q;
      op_way_d     = op_way_q;
      op_addr_d    = op_addr_q;
      op_wdata_d   = op_wdata_q;
      op_write_d   = op_write_q;
      op_lock_d    = op_lock_q;
      op_slow_d    = op_slow_q;
      cb_valid_d   = cb_valid_q;
      cb_line_d    = cb_line_q;
      cb_data_d    = cb_data_q;
      cb_mask_d    = cb_mask_q;
      resp_valid_d = 1'b0;
      resp_hit_d   = 1'b0;
      resp_rdata_d = resp_rdata_q;
      mem_req_d    = mem_req_q & ~mem_ack;
      mem_write_d  = mem_write_q;
      mem_addr_d   = mem_addr_q;
      mem_wline_d  = mem_wline_q;
      mem_wmask_d  = mem_wmask_q;
      a_we         = 1'b0;
      a_dirty      = 1'b0;
      a_lock       = 1'b0;
      a_lock_only  = 1'b0;
      a_alloc      = 1'b0;
      a_cid        = cid;
      a_set        = set;
      a_way        = hway;
      a_tag        = tag;
      a_line       = hline;
      a_ptr        = (victim == last_way) ? '0 : victim + W'(1);
      unique case (state_q)
         st_idle: begin
            if (req_valid && !resp_valid_q) begin
               if (coal && (!cb_valid_q || same_line)) begin
                  // store joins the coalescing line buffer
                  cb_valid_d = 1'b1;
                  cb_line_d  = req_addr[AW-1:cache_pkg::OFF_W];
                  cb_data_d  = put_word(cb_valid_q ? cb_data_q : '0, widx, req_wdata);
                  cb_mask_d  = (cb_valid_q ? cb_mask_q : '0) | NW'(1 << widx);
                  if (cacheable && hit) begin
                     a_we   = 1'b1;
                     a_line = put_word(hline, widx, req_wdata);
                     a_dirty = dirty_q[cid][set][hway];
                     a_lock = req_lock;
                  end
                  resp_valid_d = 1'b1;
                  resp_hit_d   = cacheable & hit;
               end else if (cacheable && hit && !wr) begin
                  a_lock_only  = req_lock;
                  resp_valid_d = 1'b1;
                  resp_hit_d   = 1'b1;
                  resp_rdata_d = word_of(hline, widx);
               end else if (to_cache_only) begin
                  a_we         = 1'b1;
                  a_dirty      = 1'b1;
                  a_lock       = req_lock;
                  a_line       = put_word(hline, widx, req_wdata);
                  resp_valid_d = 1'b1;
                  resp_hit_d   = 1'b1;
               end else if (cb_valid_q) begin
                  // keep bus order: drain pending stores before any other bus access
                  state_d     = st_flush;
                  mem_req_d   = 1'b1;
                  mem_write_d = 1'b1;
                  mem_addr_d  = {cb_line_q, 5'h0};
                  mem_wline_d = cb_data_q;
                  mem_wmask_d = cb_mask_q;
               end else begin
                  op_cid_d   = cid;
                  op_addr_d  = req_addr;
                  op_wdata_d = req_wdata;
                  op_write_d = wr;
                  op_lock_d  = req_lock;
                  op_slow_d  = req_slow;
                  op_way_d   = victim;
                  mem_req_d  = 1'b1;
                  if (alloc_req) begin
                     a_alloc = 1'b1;
                     mem_wline_d = data_q[cid][set][victim];
                     mem_wmask_d = '1;
                     if (val_q[cid][set][victim] && dirty_q[cid][set][victim]) begin
                        state_d     = st_evict;
                        mem_write_d = 1'b1;
                        mem_addr_d  = {tag_q[cid][set][victim], set, 5'h0};
                     end else begin
                        state_d     = st_fill;
                        mem_write_d = 1'b0;
                        mem_addr_d  = {req_addr[AW-1:cache_pkg::OFF_W], 5'h0};
                     end
                  end else begin
                     // uncached single word, or no free way left to allocate
                     state_d     = st_bus;
                     mem_write_d = wr;
                     mem_addr_d  = req_addr;
                     mem_wline_d = put_word('0, widx, req_wdata);
                     mem_wmask_d = NW'(1 << widx);
                  end
               end
            end else if (cb_valid_q && !req_valid) begin
               state_d     = st_flush;
               mem_req_d   = 1'b1;
               mem_write_d = 1'b1;
               mem_addr_d  = {cb_line_q, 5'h0};
               mem_wline_d = cb_data_q;
               mem_wmask_d = cb_mask_q;
            end
         end
         st_flush: begin
            if (mem_ack) begin
               cb_valid_d = 1'b0;
               cb_mask_d  = '0;
               state_d    = st_idle;
            end
         end
         st_evict: begin
            if (mem_ack) begin
               state_d     = st_fill;
               mem_req_d   = 1'b1;
               mem_write_d = 1'b0;
               mem_addr_d  = {op_addr_q[AW-1:cache_pkg::OFF_W], 5'h0};
            end
         end
         st_fill: begin
            a_cid = op_cid_q;
            a_set = op_addr_q[cache_pkg::OFF_W +: SW];
            a_way = op_way_q;
            a_tag = op_addr_q[AW-1:cache_pkg::TAG_LSB];
            a_line = op_write_q ? put_word(mem_rline, op_addr_q[cache_pkg::WSEL_LSB +: 3],
                                           op_wdata_q) : mem_rline;
            if (mem_ack) begin
               a_we         = 1'b1;
               a_dirty      = op_write_q;
               a_lock       = op_lock_q;
               state_d      = st_idle;
               resp_valid_d = 1'b1;
               resp_rdata_d = word_of(mem_rline, op_addr_q[cache_pkg::WSEL_LSB +: 3]);
            end
         end
         st_bus: begin
            if (mem_ack) begin
               state_d      = st_idle;
               resp_valid_d = 1'b1;
               resp_rdata_d = word_of(mem_rline, op_addr_q[cache_pkg::WSEL_LSB +: 3]);
            end
         end
      endcase
      resp_retry_d = (state_d == st_bus) && op_slow_d;
   end

   // ==========================================================
   // registers
   always_ff @(posedge clock) begin
      if (rst) begin
         state_q      <= st_idle;
         op_cid_q     <= cache_pkg::CID_I;
         op_way_q     <= '0;
         op_addr_q    <= '0;
         op_wdata_q   <= '0;
         op_write_q   <= 1'b0;
         op_lock_q    <= 1'b0;
         op_slow_q    <= 1'b0;
         cb_valid_q   <= 1'b0;
         cb_line_q    <= '0;
         cb_data_q    <= '0;
         cb_mask_q    <= '0;
         resp_valid_q <= 1'b0;
         resp_retry_q <= 1'b0;
         resp_hit_q   <= 1'b0;
         resp_rdata_q <= '0;
         mem_req_q    <= 1'b0;
         mem_write_q  <= 1'b0;
         mem_addr_q   <= '0;
         mem_wline_q  <= '0;
         mem_wmask_q  <= '0;
      end else begin
         state_q      <= state_d;
         op_cid_q     <= op_cid_d;
         op_way_q     <= op_way_d;
         op_addr_q    <= op_addr_d;
         op_wdata_q   <= op_wdata_d;
         op_write_q   <= op_write_d;
         op_lock_q    <= op_lock_d;
         op_slow_q    <= op_slow_d;
         cb_valid_q   <= cb_valid_d;
         cb_line_q    <= cb_line_d;
         cb_data_q    <= cb_data_d;
         cb_mask_q    <= cb_mask_d;
         resp_valid_q <= resp_valid_d;
         resp_retry_q <= resp_retry_d;
         resp_hit_q   <= resp_hit_d;
         resp_rdata_q <= resp_rdata_d;
         mem_req_q    <= mem_req_d;
         mem_write_q  <= mem_write_d;
         mem_addr_q   <= mem_addr_d;
         mem_wline_q  <= mem_wline_d;
         mem_wmask_q  <= mem_wmask_d;
      end
   end

   // arrays are written straight from the port above; a lock set beats unlock_all
   always_ff @(posedge clock) begin
      if (rst) begin
         for (int c = 0; c < NC; c++) begin
            for (int s = 0; s < SETS; s++) begin
               val_q[c][s]   <= '0;
               dirty_q[c][s] <= '0;
               lock_q[c][s]  <= '0;
               ptr_q[c][s]   <= '0;
            end
         end
      end else begin
         if (unlock_all) begin
            for (int c = 0; c < NC; c++) begin
               for (int s = 0; s < SETS; s++) begin
                  lock_q[c][s] <= '0;
               end
            end
         end
         if (a_we) begin
            tag_q[a_cid][a_set][a_way]   <= a_tag;
            data_q[a_cid][a_set][a_way]  <= a_line;
            val_q[a_cid][a_set][a_way]   <= 1'b1;
            dirty_q[a_cid][a_set][a_way] <= a_dirty;
         end
         if ((a_we && a_lock) || a_lock_only) begin
            lock_q[a_cid][a_set][a_way] <= 1'b1;
         end
         if (a_alloc) begin
            ptr_q[a_cid][a_set] <= a_ptr;
            val_q[a_cid][a_set][victim] <= 1'b0;
         end
      end
   end
endmodule
`default_nettype wire

// ==== core_cache_chk.sv ====
// port assertions for the core cache block
`timescale 1ns/100ps
`default_nettype none
module core_cache_chk (
   // clock and reset
   input wire logic                             clock,
   input wire logic                             rst,
   // core side
   input wire logic                             req_valid,
   input wire logic                             req_fetch,
   input wire logic                             req_slow,
   input wire logic [2:0]                       req_attr,
   input wire logic                             icache_en,
   input wire logic                             resp_valid_q,
   input wire logic                             resp_retry_q,
   input wire logic                             resp_hit_q,
   // memory side
   input wire logic                             mem_req_q,
   input wire logic                             mem_write_q,
   input wire logic [cache_pkg::ADDR_W-1:0]     mem_addr_q,
   input wire logic [cache_pkg::LINE_WORDS-1:0] mem_wmask_q,
   input wire logic                             mem_ack
);
   default clocking @(posedge clock);
   endclocking
   default disable iff (rst);
   // ==========================================================
   // answers to the core
   a_nc_no_hit: assert property (resp_valid_q && !req_fetch && !req_slow
      && req_attr == 3'h0 |-> !resp_hit_q) else $error("uncached load answered as hit");
   a_ifetch_off: assert property (resp_valid_q && req_fetch && !icache_en
      |-> !resp_hit_q) else $error("fetch hit while instruction cache off");
   a_slow_no_hit: assert property (resp_valid_q && req_slow
      |-> !resp_hit_q && $past(resp_retry_q)) else $error("slow answer without retry");
   a_retry_start: assert property ($rose(resp_retry_q)
      |-> $past(req_valid && req_slow)) else $error("retry without slow request");
   a_retry_hold: assert property (resp_retry_q && !mem_ack
      |=> resp_retry_q) else $error("retry dropped before bus done");
   a_retry_end: assert property ($fell(resp_retry_q)
      |-> resp_valid_q && $past(mem_ack)) else $error("retry end not tied to answer");
   // ==========================================================
   // memory side
   a_line_aligned: assert property (mem_req_q && mem_write_q && &mem_wmask_q
      |-> mem_addr_q[4:0] == 5'h0) else $error("line write not aligned");
   a_mem_hold: assert property (mem_req_q && !mem_ack
      |=> mem_req_q && $stable(mem_addr_q) && $stable(mem_write_q))
      else $error("memory request changed before ack");
endmodule
bind core_cache core_cache_chk core_cache_chk_inst (.clock(clock), .rst(rst),
   .req_valid(req_valid), .req_fetch(req_fetch), .req_slow(req_slow), .req_attr(req_attr),
   .icache_en(icache_en), .resp_valid_q(resp_valid_q), .resp_retry_q(resp_retry_q),
   .resp_hit_q(resp_hit_q), .mem_req_q(mem_req_q), .mem_write_q(mem_write_q),
   .mem_addr_q(mem_addr_q), .mem_wmask_q(mem_wmask_q), .mem_ack(mem_ack));
`default_nettype wire

// ==== core_cache_tb_top.sv ====
// self-checking bench for the core cache block
`timescale 1ns/100ps
`default_nettype none
module core_cache_tb_top;
   // ==========================================================
   // signals
   logic         clock, rst, req_valid, req_fetch, req_write, req_mini, req_lock, req_slow;
   logic         icache_en, unlock_all, resp_valid_q, resp_retry_q, resp_hit_q;
   logic         mem_req_q, mem_write_q, mem_ack, hit, rtry, chain, link;
   logic [1:0]   lat;
   logic [2:0]   req_attr;
   logic [7:0]   mem_wmask_q;
   logic [31:0]  req_addr, req_wdata, resp_rdata_q, mem_addr_q, rd, a;
   logic [255:0] mem_wline_q, mem_rline;
   logic [31:0]  shadow [int unsigned];
   int           num_errors, num_checks, seed, nwr, i, w0;
   localparam logic [2:0] ATT [4] = '{cache_pkg::ATTR_NC, cache_pkg::ATTR_WT_RA,
                                      cache_pkg::ATTR_WB_RA, cache_pkg::ATTR_WB_RWA};
   core_cache core_cache_inst (.clock(clock), .rst(rst), .req_valid(req_valid),
      .req_fetch(req_fetch), .req_write(req_write), .req_mini(req_mini), .req_lock(req_lock),
      .req_slow(req_slow), .req_attr(req_attr), .req_addr(req_addr), .req_wdata(req_wdata),
      .resp_valid_q(resp_valid_q), .resp_retry_q(resp_retry_q), .resp_hit_q(resp_hit_q),
      .resp_rdata_q(resp_rdata_q), .icache_en(icache_en), .unlock_all(unlock_all),
      .mem_req_q(mem_req_q), .mem_write_q(mem_write_q), .mem_addr_q(mem_addr_q),
      .mem_wline_q(mem_wline_q), .mem_wmask_q(mem_wmask_q), .mem_ack(mem_ack),
      .mem_rline(mem_rline));
   mem_model mem_model_inst (.clock(clock), .lat(lat), .mem_req_q(mem_req_q),
      .mem_write_q(mem_write_q), .mem_addr_q(mem_addr_q), .mem_wline_q(mem_wline_q),
      .mem_wmask_q(mem_wmask_q), .mem_ack(mem_ack), .mem_rline(mem_rline));
   initial begin
      clock = 1'b0;
      forever #50 clock = ~clock;
   end
   always @(posedge clock) begin
      if (mem_req_q && mem_ack && mem_write_q) nwr <= nwr + 1;
   end
   // ==========================================================
   // helpers
   task automatic check(input logic [31:0] seen, input logic [31:0] exp, input string what);
      num_checks++;
      if (seen !== exp) begin
         num_errors++;
         $display("unexpected %s: expected %h, seen %h", what, exp, seen);
      end
   endtask
   task automatic tally_and_finish();
      if (num_errors == 0 && num_checks > 0) $display("No errors found");
      else $display("Errors were found");
      $finish;
   endtask
   function automatic logic [31:0] expect_rd(input logic [31:0] ad);
      return shadow.exists(ad >> 2) ? shadow[ad >> 2] : {ad[31:2], 2'h0} ^ 32'h3c5a_96e1;
   endfunction
   // request held until the answer, then dropped, or replaced at once when chained
   task automatic access(input logic f, w, m, l, s, input logic [2:0] at,
                         input logic [31:0] ad, d);
      int n;
      if (!link) @(posedge clock);
      link = chain;
      {req_valid, req_fetch, req_write, req_mini, req_lock, req_slow} <= {1'b1, f, w, m, l, s};
      {req_attr, req_addr, req_wdata} <= {at, ad, d};
      rtry = 1'b0;
      n = 0;
      do begin
         @(negedge clock);
         rtry |= resp_retry_q;
         n++;
      end while (resp_valid_q !== 1'b1 && n < 300);
      if (n >= 300) begin
         num_errors++;
         tally_and_finish();
      end
      hit = resp_hit_q;
      rd = resp_rdata_q;
      @(posedge clock);
      if (!chain) req_valid <= 1'b0;
      if (w && !f) shadow[ad >> 2] = d;
   endtask
   // eh of 2 leaves the hit flag unchecked
   task automatic ld(input logic f, m, l, input logic [2:0] at, input logic [31:0] ad,
                     input logic [1:0] eh);
      access(f, 1'b0, m, l, 1'b0, at, ad, 32'h0);
      check(rd, expect_rd(ad), "load data");
      if (eh != 2'h2) check({31'h0, hit}, {30'h0, eh}, "hit flag");
   endtask
   // ==========================================================
   // main sequence
   initial begin
      {seed, num_errors, num_checks, nwr, lat, rst} = {32'd31, 96'h0, 2'h1, 1'b1};
      {req_valid, req_fetch, req_write, req_mini, req_lock, req_slow} = 6'h0;
      {icache_en, unlock_all, chain, link, req_attr, req_addr, req_wdata} = '0;
      repeat (8) @(posedge clock);
      rst <= 1'b0;
      ld(0, 0, 0, 3'h0, 32'h100, 2'h0);
      ld(0, 0, 0, 3'h0, 32'h100, 2'h0);
      ld(1, 0, 0, 3'h3, 32'h200, 2'h0);
      ld(1, 0, 0, 3'h3, 32'h200, 2'h0);
      icache_en <= 1'b1;
      ld(1, 0, 0, 3'h3, 32'h200, 2'h2);
      ld(1, 0, 0, 3'h3, 32'h200, 2'h1);
      ld(0, 0, 0, 3'h3, 32'h400, 2'h2);
      ld(1, 0, 0, 3'h3, 32'h400, 2'h0);
      access(0, 1, 0, 0, 0, 3'h2, 32'h800, 32'h1111_2222);
      ld(0, 0, 0, 3'h2, 32'h800, 2'h0);
      access(0, 1, 0, 0, 0, 3'h7, 32'h884, 32'h3333_4444);
      ld(0, 0, 0, 3'h7, 32'h884, 2'h1);
      ld(0, 0, 0, 3'h3, 32'hc00, 2'h2);
      w0 = nwr;
      access(0, 1, 0, 0, 0, 3'h3, 32'hc00, 32'h5555_6666);
      repeat (20) @(posedge clock);
      check(nwr, w0, "write-back bus writes");
      ld(0, 0, 0, 3'h2, 32'hd00, 2'h2);
      w0 = nwr;
      chain = 1'b1;
      access(0, 1, 0, 0, 0, 3'h1, 32'hf00, 32'h1234_5678);
      chain = 1'b0;
      access(0, 1, 0, 0, 0, 3'h1, 32'hf04, 32'h9abc_def0);
      access(0, 1, 0, 0, 0, 3'h2, 32'hd00, 32'h7777_8888);
      access(0, 1, 0, 0, 0, 3'h0, 32'he00, 32'h9999_aaaa);
      access(0, 1, 0, 0, 0, 3'h0, 32'he04, 32'hbbbb_cccc);
      repeat (20) @(posedge clock);
      check(nwr, w0 + 4, "through, coalesced and uncached bus writes");
      ld(0, 0, 0, 3'h0, 32'hd00, 2'h0);
      ld(0, 0, 0, 3'h0, 32'he04, 2'h0);
      access(0, 0, 0, 0, 1, 3'h3, 32'h1000, 32'h0);
      check({31'h0, rtry}, 32'h1, "retry seen");
      check(rd, expect_rd(32'h1000), "slow data");
      for (i = 0; i < 3; i++) ld(0, 1, 0, 3'h3, 32'h2000 + i * 1024, 2'h2);
      ld(0, 1, 0, 3'h3, 32'h2000, 2'h0);
      ld(1, 0, 1, 3'h3, 32'h4000, 2'h2);
      ld(0, 0, 1, 3'h3, 32'h8060, 2'h2);
      for (i = 1; i <= 32; i++) begin
         ld(1, 0, 0, 3'h3, 32'h4000 + i * 1024, 2'h2);
         ld(0, 0, 0, 3'h3, 32'h8060 + i * 1024, 2'h2);
      end
      ld(1, 0, 0, 3'h3, 32'h4000, 2'h1);
      ld(0, 0, 0, 3'h3, 32'h8060, 2'h1);
      ld(1, 0, 0, 3'h3, 32'h4400, 2'h0);
      ld(0, 0, 0, 3'h3, 32'h8460, 2'h0);
      unlock_all <= 1'b1;
      @(posedge clock);
      unlock_all <= 1'b0;
      // region bits pick a fixed policy and target, so cached copies stay coherent
      for (i = 0; i < 400; i++) begin
         w0 = $random(seed);
         a = {16'h0001, 1'b0, w0[14:12], w0[11:8], 1'b0, w0[6:5], w0[4:2], 2'h0};
         lat <= w0[17:16];
         access(0, w0[15], w0[14], 0, 0, ATT[w0[13:12]], a, $random(seed));
         if (!w0[15]) check(rd, expect_rd(a), "random load data");
      end
      tally_and_finish();
   end
endmodule
`default_nettype wire

// ==== mem_model.sv ====
// line-wide memory answering fills, evictions and single accesses
`timescale 1ns/100ps
`default_nettype none
module mem_model (
   // clock and latency
   input  wire logic         clock,
   input  wire logic [1:0]   lat,
   // memory port
   input  wire logic         mem_req_q,
   input  wire logic         mem_write_q,
   input  wire logic [31:0]  mem_addr_q,
   input  wire logic [255:0] mem_wline_q,
   input  wire logic [7:0]   mem_wmask_q,
   output logic              mem_ack,
   output logic      [255:0] mem_rline
);
   // ==========================================================
   // storage, unwritten words read as an address pattern
   logic [31:0] mem [int unsigned];
   logic [31:0] wa;
   int          wait_n;
   initial begin
      mem_ack = 1'b0;
      mem_rline = '0;
      wait_n = 0;
   end
   // read line flips when idle so a stale line never passes for an answer
   always @(posedge clock) begin
      if (mem_req_q && !mem_ack && wait_n >= lat) begin
         for (int k = 0; k < 8; k++) begin
            wa = {mem_addr_q[31:5], 5'h0} + 4 * k;
            if (mem_write_q && mem_wmask_q[k]) mem[wa >> 2] = mem_wline_q[32*k +: 32];
            mem_rline[32*k +: 32] <= mem.exists(wa >> 2) ? mem[wa >> 2] : wa ^ 32'h3c5a_96e1;
         end
         mem_ack <= 1'b1;
         wait_n = 0;
      end else begin
         mem_ack <= 1'b0;
         mem_rline <= ~mem_rline;
         if (mem_req_q && !mem_ack) wait_n++;
      end
   end
endmodule
`default_nettype wire

// ==== rr_victim.sv ====
// round-robin victim picker that skips unavailable (locked or absent) ways
`timescale 1ns/100ps
`default_nettype none
module rr_victim #(
   parameter int WAYS = 32
) (
   // pointer and candidate mask
   input  wire logic [$clog2(WAYS)-1:0] ptr,
   input  wire logic [WAYS-1:0]         avail,
   // choice
   output logic      [$clog2(WAYS)-1:0] victim,
   output logic                         none
);
   localparam int W = $clog2(WAYS);

   // searches from the pointer upward; WAYS must be a power of two so the index wraps
   always_comb begin
      logic [W-1:0] idx;
      idx    = '0;
      victim = ptr;
      none   = 1'b1;
      for (int i = WAYS - 1; i >= 0; i--) begin
         idx = ptr + W'(i);
         if (avail[idx]) begin
            victim = idx;
            none   = 1'b0;
         end
      end
   end
endmodule
`default_nettype wire
